// File: include/pwr_regs.svh
// Register offsets, field positions, reset values and timing counts of the power-down controller
`ifndef PWR_REGS_SVH
`define PWR_REGS_SVH

// Register byte offsets
`define OFS_MODE        12'h000
`define OFS_PERIOD      12'h004
`define OFS_WAKE_EN     12'h008
`define OFS_STATUS      12'h00C

// Mode register field positions
`define B_IDLE_SEL      0
`define B_SYSCLK_KEEP   1
`define B_FAST_WAKE     2
`define B_WDT_EN        3
`define B_LVD_EN        4
`define B_WDT_SRC_SYS   5
`define B_SUB_LXT       6
`define B_SYS_HXT       7
`define B_SYS_ON_SUB    8
`define MODE_W          9

// Status register field positions
`define B_ST_STATE      0
`define B_ST_PD         8
`define B_ST_TO         9
`define B_ST_HS_RDY     10
`define B_ST_LS_RDY     11
`define B_ST_CPU_RUN    12

// Reset values
`define MODE_RST        9'h008
`define PERIOD_RST      3'h3
`define WAKE_EN_RST     8'h00
`define GATE_RST        6'h3E

// Start-up timer counts, in oscillator cycles, and the watchdog base limit
`define SST_HXT         11'h080
`define SST_HS_INTERNAL_OSC        11'h010
`define SST_LXT         11'h400
`define WDT_BASE_LIM    16'h00FF

`endif

// File: include/pwr_pkg.sv
// Types shared by the power-down controller
package pwr_pkg;

  typedef enum logic [5:0] {
    ST_RUN   = 6'h01,
    ST_DEEP  = 6'h02,
    ST_LIGHT = 6'h04,
    ST_IDLE_CLOCK_STOPPED_STATE = 6'h08,
    ST_IDLE_CLOCK_RUNNING_STATE = 6'h10,
    ST_START = 6'h20
  } pwr_state_t;

  typedef struct packed {
    logic cpu_run;
    logic sys_clk_run;
    logic tb_clk_run;
    logic sub_clk_run;
    logic hs_osc_on;
    logic sys_on_sub;
  } clk_gate_t;

endpackage : pwr_pkg

// File: core/halt_power_down_wake_control.sv
// Halt power-down, wake-up and watchdog controller with APB register access
//
// Functional notes
// [R1] Halt, idle off, watchdog/detector off: deep sleep
// [R2] Deep sleep stops system, sub clocks; watchdog cleared
// [R3] Halt, idle off, watchdog or detector on: light
// [R4] Light sleep stops system, time-base; sub runs
// [R5] Light sleep clears watchdog; sub-clocked keeps counting
// [R6] Halt, idle on, keep off: clock-stopped idle
// [R7] Clock-stopped idle: sub-clocked watchdog counts, system stops
// [R8] Halt, idle on, keep on: clock-running idle
// [R9] Clock-running idle: enabled watchdog cleared, keeps counting
// [R10] Sleep/idle stops execution; state held
// [R11] Halt sets power-down, clears timeout; clear-watchdog clears
// [R12] Wake on port A fall, interrupt, watchdog overflow
// [R13] Sleep timeout sets flag, resets PC/SP only
// [R14] Per-pin port A wake enable; resume after halt
// [R15] Interrupt wake resumes after halt; service later
// [R16] Interrupt pending before halt cannot wake
// [R17] Crystals share start-up timer; low-speed after high
// [R18] Deep-sleep wake executes after oscillator ready
// [R19] Watchdog source: sub clock or system/4
// [R20] Watchdog period 2^8..2^15 by select field
// [R21] System peripherals follow system clock switch
// [R22] Sub clock runs per watchdog enable
// [R23] Fast wake runs on sub for 128 cycles
`timescale 1ns/1ps
`include "pwr_regs.svh"

module halt_power_down_wake_control
  import pwr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        halt_exec,
  input  wire logic        clr_wdt_exec,
  input  wire logic [7:0]  porta_in,
  input  wire logic [7:0]  irq_req,
  input  wire logic        sub_tick,
  output clk_gate_t        clk_gate,
  output logic             powerdown_flag,
  output logic             watchdog_timeout_flag,
  output logic             hs_osc_ready_flag,
  output logic             wake_resume,
  output logic             pc_sp_reset,
  output logic             wdt_reset_req
);

  // Every register of the block lives in this one struct: s_nxt is worked out
  // combinationally each cycle and s_r takes it on the clock edge.
  // The one-cycle pulses (wake, pcsp, wdt_rst) default low in s_nxt, so a
  // pulse lasts exactly one clock unless its cause is still present.
  typedef struct packed {
    pwr_state_t         state;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
    logic [`MODE_W-1:0] mode;
    logic [2:0]         period;
    logic [7:0]         wake_en;
    logic [7:0]         pa_q;
    logic [7:0]         irq_mask;
    logic [15:0]        wcnt;
    logic [1:0]         presc;
    logic [10:0]        osc_startup_timer;
    logic               hxt_busy;
    logic               lxt_busy;
    logic               hs_ready;
    logic               ls_ready;
    logic               pd;
    logic               to;
    logic               wake;
    logic               pcsp;
    logic               wdt_rst;
    logic               fast_sub;
    clk_gate_t          gate;
  } regs_t;

  regs_t s_r;
  regs_t s_nxt;

  // Decoded mode bits and helper terms; the mode bits decoded here are read from s_r, so no
  // combinational path runs from an APB write into the sleep decision.
  logic        idle_sel;
  logic        sys_keep;
  logic        fast_en;
  logic        wdt_en;
  logic        lvd_en;
  logic        src_sys;
  logic        sub_lxt;
  logic        sys_hxt;
  logic        sleeping;
  logic        sys_running;
  logic        sub_running;
  logic        wdt_tick;
  logic        overflow;
  logic [15:0] wdt_lim;
  logic [7:0]  pa_fall;
  logic [7:0]  irq_new;
  logic        wake_ev;
  logic        wr_acc;
  logic [31:0] rd_val;
  logic        rd_hit;

  // Mode bits
  assign idle_sel = s_r.mode[`B_IDLE_SEL];
  assign sys_keep = s_r.mode[`B_SYSCLK_KEEP];
  assign fast_en  = s_r.mode[`B_FAST_WAKE];
  assign wdt_en   = s_r.mode[`B_WDT_EN];
  assign lvd_en   = s_r.mode[`B_LVD_EN];
  assign src_sys  = s_r.mode[`B_WDT_SRC_SYS];
  assign sub_lxt  = s_r.mode[`B_SUB_LXT];
  assign sys_hxt  = s_r.mode[`B_SYS_HXT];

  assign sleeping = (s_r.state == ST_DEEP) || (s_r.state == ST_LIGHT) ||
                    (s_r.state == ST_IDLE_CLOCK_STOPPED_STATE) || (s_r.state == ST_IDLE_CLOCK_RUNNING_STATE);

  // Clock activity seen by the watchdog
  assign sys_running = s_r.gate.sys_clk_run;
  assign sub_running = s_r.gate.sub_clk_run;

  // A tick is only honoured while its source clock is ungated, so gating a
  // clock in a standby state also freezes a watchdog that runs from it,
  // which is how the clock-stopped states halt a system-clocked watchdog.
  // Watchdog source: sub clock, or system clock divided by four
  assign wdt_tick = wdt_en && (src_sys ? (sys_running && (s_r.presc == 2'h3))
                                       : (sub_running && sub_tick)); // [R19]

  // Period limit 2^(8+sel)-1
  assign wdt_lim  = 16'((32'(`WDT_BASE_LIM) << s_r.period) | 32'(s_r.period != 3'h0)
                        * ((32'h1 << s_r.period) - 32'h1)); // [R20]
  // Greater-or-equal, not equal: if the period is shortened while the count
  // already stands beyond the new limit, it times out at once instead of
  // running round all 16 bits first.
  assign overflow = wdt_tick && (s_r.wcnt >= wdt_lim);

  // Port A edges are found against last cycle's sample; pa_q resets high,
  // the idle level of the pins, so no false edge follows reset.
  // Wake sources; interrupts armed only if not already pending at halt
  assign pa_fall = s_r.pa_q & ~porta_in & s_r.wake_en; // [R14]
  assign irq_new = irq_req & s_r.irq_mask; // [R16]
  assign wake_ev = (|pa_fall) || (|irq_new) || overflow; // [R12]

  // The slave answers in the first access cycle, so a write lands at the
  // edge where the master samples pready high and at no other.
  // APB access phase completes on the registered ready
  assign wr_acc = psel && penable && pwrite && s_r.pready;

  // Read mux
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (paddr)
      `OFS_MODE:    rd_val[`MODE_W-1:0] = s_r.mode;
      `OFS_PERIOD:  rd_val[2:0] = s_r.period;
      `OFS_WAKE_EN: rd_val[7:0] = s_r.wake_en;
      `OFS_STATUS:
      begin
        rd_val[`B_ST_STATE +: 6] = s_r.state;
        rd_val[`B_ST_PD]         = s_r.pd;
        rd_val[`B_ST_TO]         = s_r.to;
        rd_val[`B_ST_HS_RDY]     = s_r.hs_ready;
        rd_val[`B_ST_LS_RDY]     = s_r.ls_ready;
        rd_val[`B_ST_CPU_RUN]    = s_r.gate.cpu_run;
      end
      default:      rd_hit = 1'b0;
    endcase
  end

  // Next-state logic for the whole block
  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.wake    = 1'b0;
    s_nxt.pcsp    = 1'b0;
    s_nxt.wdt_rst = 1'b0;
    s_nxt.pa_q    = porta_in;

    // Zero-wait APB slave: ready rises after the setup cycle
    s_nxt.pready = psel && !penable && !s_r.pready;
    if (psel && !penable)
    begin
      s_nxt.prdata  = pwrite ? 32'h0000_0000 : rd_val;
      s_nxt.pslverr = !rd_hit;
    end
    if (wr_acc)
    begin
      unique case (paddr)
        `OFS_MODE:    s_nxt.mode = pwdata[`MODE_W-1:0];
        `OFS_PERIOD:  s_nxt.period = pwdata[2:0];
        `OFS_WAKE_EN: s_nxt.wake_en = pwdata[7:0];
        default:      s_nxt.period = s_r.period; // Status and unmapped ignore writes
      endcase
    end

    // Watchdog counter and system/4 prescaler
    if (sys_running)
      s_nxt.presc = 2'(s_r.presc + 2'h1);
    if (wdt_tick)
      s_nxt.wcnt = overflow ? 16'h0000 : 16'(s_r.wcnt + 16'h0001);
    if (clr_wdt_exec)
    begin
      s_nxt.wcnt = 16'h0000;
      s_nxt.pd   = 1'b0; // [R11]
    end

    // Halt is only honoured while the core runs; in a standby state the core
    // cannot execute it, so a stray pulse there is ignored.
    unique case (s_r.state)
      ST_RUN:
      begin
        if (overflow)
          s_nxt.wdt_rst = 1'b1;
        if (halt_exec)
        begin
          s_nxt.wcnt     = 16'h0000; // [R2] [R5] [R9]
          s_nxt.presc    = 2'h0;
          s_nxt.pd       = 1'b1; // [R11]
          s_nxt.to       = 1'b0; // [R11]
          s_nxt.irq_mask = ~irq_req; // [R16]
          if (!idle_sel && !wdt_en && !lvd_en)
            s_nxt.state = ST_DEEP; // [R1]
          else if (!idle_sel)
            s_nxt.state = ST_LIGHT; // [R3]
          else if (!sys_keep)
            s_nxt.state = ST_IDLE_CLOCK_STOPPED_STATE; // [R6]
          else
            s_nxt.state = ST_IDLE_CLOCK_RUNNING_STATE; // [R8]
        end
      end
      ST_DEEP, ST_LIGHT, ST_IDLE_CLOCK_STOPPED_STATE, ST_IDLE_CLOCK_RUNNING_STATE:
      begin
        if (s_r.state == ST_DEEP)
          s_nxt.wcnt = 16'h0000; // [R2]
        if (wake_ev)
        begin
          s_nxt.wake = 1'b1; // [R14] [R15]
          if (overflow)
          begin
            s_nxt.to   = 1'b1; // [R13]
            s_nxt.pcsp = 1'b1; // [R13]
          end
          if (s_r.state == ST_IDLE_CLOCK_RUNNING_STATE)
            s_nxt.state = ST_RUN;
          else if (s_r.state != ST_DEEP && sys_hxt && fast_en)
          begin
            // Run from the sub clock while the crystal starts
            s_nxt.state    = ST_RUN; // [R23]
            s_nxt.fast_sub = 1'b1; // [R23]
            s_nxt.hxt_busy = 1'b1;
            s_nxt.osc_startup_timer      = 11'h000;
          end
          else
          begin
            s_nxt.state    = ST_START;
            s_nxt.hxt_busy = 1'b1;
            s_nxt.osc_startup_timer      = 11'h000;
          end
          if (s_r.state == ST_DEEP && sub_lxt)
            s_nxt.lxt_busy = 1'b1; // [R17]
        end
      end
      ST_START:
      begin
        if (!s_r.hxt_busy)
          s_nxt.state = ST_RUN; // [R18]
      end
      default:
        s_nxt.state = ST_RUN;
    endcase

    // Both crystals use one counter, so the low-speed crystal waits for the
    // high-speed one; the core may therefore run before the low-speed crystal
    // is ready, which software sees in the ls ready status bit.
    // Start-up counts are in pclk cycles, a stand-in for oscillator cycles.
    // Shared start-up timer: high-speed first, then low-speed crystal
    if (s_r.hxt_busy)
    begin
      s_nxt.osc_startup_timer = 11'(s_r.osc_startup_timer + 11'h001);
      if (s_r.osc_startup_timer == 11'(32'(sys_hxt ? `SST_HXT : `SST_HS_INTERNAL_OSC) - 32'd1))
      begin
        s_nxt.hxt_busy = 1'b0;
        s_nxt.hs_ready = 1'b1; // [R18]
        s_nxt.fast_sub = 1'b0; // [R23]
        s_nxt.osc_startup_timer      = 11'h000;
      end
    end
    else if (s_r.lxt_busy)
    begin
      s_nxt.osc_startup_timer = 11'(s_r.osc_startup_timer + 11'h001); // [R17]
      if (s_r.osc_startup_timer == 11'(32'(`SST_LXT) - 32'd1))
      begin
        s_nxt.lxt_busy = 1'b0;
        s_nxt.ls_ready = 1'b1;
        s_nxt.osc_startup_timer      = 11'h000;
      end
    end

    // The high-speed oscillator stops in every standby state but clock-running idle;
    // its ready flag falls with it so the next wake waits a full start-up.
    // Oscillators stopping lose their ready flags
    if (s_nxt.state == ST_DEEP || s_nxt.state == ST_LIGHT || s_nxt.state == ST_IDLE_CLOCK_STOPPED_STATE)
      s_nxt.hs_ready = 1'b0;
    if (s_nxt.state == ST_DEEP && sub_lxt)
      s_nxt.ls_ready = 1'b0;

    // A timeout in a standby state sets the flag; halt beats a same-cycle clear-watchdog
    if (overflow && sleeping)
      s_nxt.to = 1'b1;
    if (halt_exec && s_r.state == ST_RUN)
      s_nxt.pd = 1'b1; // [R11]

    // Clock gates follow the next state so outputs stay registered
    s_nxt.gate.cpu_run     = (s_nxt.state == ST_RUN); // [R10]
    s_nxt.gate.sys_clk_run = (s_nxt.state == ST_RUN) || (s_nxt.state == ST_IDLE_CLOCK_RUNNING_STATE); // [R2] [R4]
    s_nxt.gate.tb_clk_run  = (s_nxt.state == ST_RUN) || (s_nxt.state == ST_IDLE_CLOCK_STOPPED_STATE) ||
                             (s_nxt.state == ST_IDLE_CLOCK_RUNNING_STATE); // [R4] [R7] [R8]
    unique case (s_nxt.state)
      ST_DEEP:  s_nxt.gate.sub_clk_run = 1'b0; // [R2]
      ST_LIGHT: s_nxt.gate.sub_clk_run = 1'b1; // [R4]
      ST_IDLE_CLOCK_STOPPED_STATE, ST_IDLE_CLOCK_RUNNING_STATE: s_nxt.gate.sub_clk_run = 1'b1; // [R7] [R8]
      default:  s_nxt.gate.sub_clk_run = (wdt_en && !src_sys) || lvd_en ||
                                         s_nxt.mode[`B_SYS_ON_SUB] || s_nxt.fast_sub; // [R22]
    endcase
    s_nxt.gate.hs_osc_on  = s_nxt.gate.sys_clk_run || s_nxt.hxt_busy;
    // Peripherals on the system clock follow it onto the sub clock
    s_nxt.gate.sys_on_sub = s_nxt.gate.sys_clk_run &&
                            (s_nxt.mode[`B_SYS_ON_SUB] || s_nxt.fast_sub); // [R21] [R23]
  end

  // Asynchronous reset puts the block in the run state on the high-speed
  // clock with both oscillators ready, as after a completed power-up.
  // Single state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r          <= '0;
      s_r.state    <= ST_RUN;
      s_r.mode     <= `MODE_RST;
      s_r.period   <= `PERIOD_RST;
      s_r.wake_en  <= `WAKE_EN_RST;
      s_r.pa_q     <= 8'hFF;
      s_r.hs_ready <= 1'b1;
      s_r.ls_ready <= 1'b1;
      s_r.gate     <= `GATE_RST; // Running on the high-speed clock
    end
    else
      s_r <= s_nxt;
  end

  // Every output is a field of s_r, so none has a combinational path from
  // an input.
  // Outputs straight from the state register
  assign prdata                = s_r.prdata;
  assign pready                = s_r.pready;
  assign pslverr               = s_r.pslverr;
  assign clk_gate              = s_r.gate;
  assign powerdown_flag        = s_r.pd;
  assign watchdog_timeout_flag = s_r.to;
  assign hs_osc_ready_flag     = s_r.hs_ready;
  assign wake_resume           = s_r.wake;
  assign pc_sp_reset           = s_r.pcsp;
  assign wdt_reset_req         = s_r.wdt_rst;

endmodule : halt_power_down_wake_control

// File: verification/cpu_model.sv
// Core-side model: issues halt and clear-watchdog, makes sub clock ticks
`timescale 1ns/1ps
module cpu_model
  import pwr_pkg::*;
#(parameter int SUB_DIV = 2)
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic halt_req,
  input  wire logic clr_req,
  input  clk_gate_t clk_gate,
  output logic      halt_exec,
  output logic      clr_wdt_exec,
  output logic      sub_tick
);
  int div;
  // A stopped core issues nothing, so requests are dropped while it sleeps
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      div <= 0;
      halt_exec <= 1'b0;
      clr_wdt_exec <= 1'b0;
      sub_tick <= 1'b0;
    end
    else
    begin
      div <= (div == SUB_DIV - 1) ? 0 : div + 1;
      sub_tick <= (div == SUB_DIV - 1);
      halt_exec <= halt_req && clk_gate.cpu_run;
      clr_wdt_exec <= clr_req && clk_gate.cpu_run;
    end
endmodule : cpu_model

// File: verification/halt_power_down_wake_control_props.sv
// Port-level assertions of the power-down controller
`timescale 1ns/1ps
module pwr_props
  import pwr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic halt_exec,
  input wire logic clr_wdt_exec,
  input clk_gate_t clk_gate,
  input wire logic powerdown_flag,
  input wire logic watchdog_timeout_flag,
  input wire logic hs_osc_ready_flag,
  input wire logic wake_resume,
  input wire logic pc_sp_reset,
  input wire logic wdt_reset_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  halt_enter_a: assert property (halt_exec && clk_gate.cpu_run |=>
    !clk_gate.cpu_run && powerdown_flag && !watchdog_timeout_flag)
    else $error("halt did not stop core or set flags");
  clr_pd_a: assert property (clr_wdt_exec && !halt_exec |=> !powerdown_flag)
    else $error("clear-watchdog left power-down set");
  idle_gate_a: assert property (!clk_gate.cpu_run && clk_gate.sys_clk_run
    && hs_osc_ready_flag |-> clk_gate.tb_clk_run && clk_gate.sub_clk_run)
    else $error("system clock kept without others");
  to_wake_a: assert property (pc_sp_reset |-> watchdog_timeout_flag
    && $stable(powerdown_flag)) else $error("timeout wake flags wrong");
  wake_stop_a: assert property (wake_resume |-> !$past(clk_gate.cpu_run))
    else $error("wake while running");
  run_reset_a: assert property (wdt_reset_req |-> clk_gate.cpu_run && !pc_sp_reset)
    else $error("running overflow mixed with wake");
  start_ready_a: assert property ($rose(clk_gate.cpu_run) |->
    hs_osc_ready_flag || clk_gate.sys_on_sub) else $error("core ran before osc ready");
  ready_drop_a: assert property ($fell(hs_osc_ready_flag) |-> !clk_gate.cpu_run)
    else $error("osc not ready while core runs");
  wake_c: cover property (wake_resume);
  to_wake_c: cover property (pc_sp_reset);
  run_ovf_c: cover property (wdt_reset_req);
endmodule : pwr_props
bind halt_power_down_wake_control pwr_props pwr_props_i (.*);

// File: verification/tb.sv
// Self-checking bench for the halt power-down and wake controller
`timescale 1ns/1ps
`include "pwr_regs.svh"
module tb
  import pwr_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, e, halt_req = 0, clr_req = 0, halt_exec, clr_wdt_exec, sub_tick;
  logic [7:0] porta_in = 8'hFF, irq_req = 8'h00;
  clk_gate_t clk_gate;
  logic powerdown_flag, watchdog_timeout_flag, hs_osc_ready_flag;
  logic wake_resume, pc_sp_reset, wdt_reset_req;
  int mismatches = 0, n_tests = 0, cyc = 0, c;
  wire logic [3:0] ev = {wdt_reset_req, pc_sp_reset, wake_resume, clk_gate.cpu_run};
  halt_power_down_wake_control halt_power_down_wake_control_i (.*);
  cpu_model #(.SUB_DIV(2)) cpu_model_i (.*);
  // Clock, and a ceiling well above the longest watchdog run
  initial forever #25 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, x);
    n_tests++;
    if (s !== x)
    begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", nm, x, s);
    end
  endtask : chk
  // APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Bounded wait for one event bit, edges counted in c
  task automatic wt(input int k);
    c = 0;
    do
    begin
      @(posedge pclk);
      c++;
    end
    while (ev[k] !== 1'b1 && c < 5000);
  endtask : wt
  task automatic pulse(input logic h);
    {halt_req, clr_req} <= h ? 2'h2 : 2'h1;
    @(posedge pclk);
    {halt_req, clr_req} <= 2'h0;
    repeat (3) @(posedge pclk);
  endtask : pulse
  function automatic pwr_state_t exp_st(input logic [8:0] m);
    if (!m[`B_IDLE_SEL])
      return (m[`B_WDT_EN] | m[`B_LVD_EN]) ? ST_LIGHT : ST_DEEP;
    return m[`B_SYSCLK_KEEP] ? ST_IDLE_CLOCK_RUNNING_STATE : ST_IDLE_CLOCK_STOPPED_STATE;
  endfunction : exp_st
  function automatic logic [2:0] exp_gt(input pwr_state_t s);
    case (s)
      ST_LIGHT: return 3'h1;
      ST_IDLE_CLOCK_STOPPED_STATE: return 3'h3;
      ST_IDLE_CLOCK_RUNNING_STATE: return 3'h7;
      default: return 3'h0;
    endcase
  endfunction : exp_gt
  function automatic int exp_dly(input logic [8:0] m, input pwr_state_t s);
    if (s == ST_IDLE_CLOCK_RUNNING_STATE || (s != ST_DEEP && m[`B_FAST_WAKE] && m[`B_SYS_HXT]))
      return 0;
    return m[`B_SYS_HXT] ? 128 : 16;
  endfunction : exp_dly
  // Main sequence: registers, each standby state, watchdog
  initial
  begin
    logic [8:0] m;
    static logic [8:0] tbl [5] = '{9'h000, 9'h008, 9'h001, 9'h003, 9'h094};
    int k, p, n;
    pwr_state_t s;
    k = $urandom(96239);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `OFS_MODE, 0);
    chk("mode", q, `MODE_RST);
    apb(0, `OFS_PERIOD, 0);
    chk("period", q, `PERIOD_RST);
    apb(0, `OFS_WAKE_EN, 0);
    chk("wake_en", q, `WAKE_EN_RST);
    apb(1, `OFS_STATUS, 32'h0);
    apb(0, `OFS_STATUS, 0);
    chk("status", q, 32'h1C01);
    apb(0, 12'h010, 0);
    chk("slverr", e, 1'h1);
    $display("test regs done");
    for (int i = 0; i < 5; i++)
    begin
      m = tbl[i];
      if (i == 0) m[`B_SYS_HXT] = $urandom_range(0, 1);
      k = $urandom_range(0, 7);
      p = (k + 3) % 8;
      irq_req <= 8'h01 << p;
      apb(1, `OFS_MODE, m);
      apb(1, `OFS_WAKE_EN, 32'h1 << k);
      pulse(1);
      s = exp_st(m);
      apb(0, `OFS_STATUS, 0);
      chk("state", q[5:0], s);
      chk("gates", {clk_gate.sys_clk_run, clk_gate.tb_clk_run, clk_gate.sub_clk_run}, exp_gt(s));
      chk("hs_osc", clk_gate.hs_osc_on, s == ST_IDLE_CLOCK_RUNNING_STATE);
      chk("pd_to", {powerdown_flag, watchdog_timeout_flag}, 2'h2);
      porta_in[(k + 1) % 8] <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("stay", {clk_gate.cpu_run, wake_resume}, 2'h0);
      if (i[0]) irq_req[k] <= 1'b1;
      else porta_in[k] <= 1'b0;
      wt(1);
      wt(0);
      n = exp_dly(m, s);
      chk("delay", c >= n - 1 && c <= n + 3, 1'h1);
      if (i == 4) chk("on_sub", clk_gate.sys_on_sub, 1'h1);
      chk("hs_ready", hs_osc_ready_flag, i != 4);
      porta_in <= 8'hFF;
      irq_req <= 8'h00;
      @(posedge pclk);
      $display("test sleep %0d done", i);
    end
    for (int j = 0; j < 2; j++)
    begin
      k = $urandom_range(0, 1);
      apb(1, `OFS_PERIOD, k);
      apb(1, `OFS_MODE, j ? 32'h028 : 32'h008);
      pulse(0);
      wt(3);
      n = (1 << (8 + k)) * (j ? 4 : 2);
      chk("wdt_period", c > n - 9 && c < n + 9, 1'h1);
      $display("test watchdog %0d done", j);
    end
    apb(1, `OFS_PERIOD, 0);
    apb(1, `OFS_MODE, 32'h008);
    pulse(1);
    wt(2);
    @(posedge pclk);
    chk("to_wake", {watchdog_timeout_flag, powerdown_flag}, 2'h3);
    wt(0);
    pulse(0);
    chk("pd_clr", powerdown_flag, 1'h0);
    pulse(1);
    chk("to_clr", watchdog_timeout_flag, 1'h0);
    $display("test timeout done");
    end_sim();
  end
  task automatic end_sim;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
endmodule : tb
